// *** sstc_cfg.svh ***
// Offsets, field positions and reset values of the safe state block
`ifndef SSTC_CFG_SVH
`define SSTC_CFG_SVH
`define SSTC_PHASES         8
`define SSTC_LATCHED_W      8
`define SSTC_CONFIG_W       8
`define SSTC_OFF_STATUS     12'h000
`define SSTC_OFF_IRQ_STAT   12'h004
`define SSTC_OFF_IRQ_MASK   12'h008
`define SSTC_OFF_FRS        12'h00C
`define SSTC_OFF_PHASE_EN   12'h010
`define SSTC_OFF_PHASE_DAT  12'h014
`define SSTC_BIT_SAFE       0
`define SSTC_BIT_ECHO       1
`define SSTC_BIT_MAIN       2
`define SSTC_BIT_EV_SAFE    0
`define SSTC_BIT_EV_ECHO    1
`define SSTC_BIT_EV_LATCH   2
`define SSTC_BIT_EV_CONFIG  3
`define SSTC_IRQ_W          4
`define SSTC_RST_FRS        8'h00
`define SSTC_RST_MASK       4'h0
`define SSTC_HTRANS_NONSEQ  2'b10
`endif

// *** sstc_pkg.sv ***
// Types shared by the safe state block
package sstc_pkg;
   typedef enum logic [1:0]
   {
      SSTC_RUN,
      SSTC_MAIN_SAFE,
      SSTC_PROT_SAFE
   } sstc_state_type;
endpackage

// *** sstc_prot_path.sv ***
// Isolated protected switch-off path with its own trip latch
`timescale 1ns/1ps
`include "sstc_cfg.svh"
module sstc_prot_path
(
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic ov_s,
   input  wire logic uv_s,
   input  wire logic tmo_s,
   output logic      trip_q
);
   logic trip_d;

   // Reads only its own latch and the three synchronised monitors, never main logic state
   always_comb
   begin
      trip_d = trip_q | ov_s | uv_s | tmo_s;
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         trip_q <= 1'b0;
      else
         trip_q <= trip_d;
   end
endmodule

// *** sstc_safe_state_top.sv ***
// Safe state tristate control with AHB-Lite register slave
//
// Added by the designer: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`include "sstc_cfg.svh"
module sstc_safe_state_top
(
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic [7:0]  latched_fault,
   input  wire logic [7:0]  config_fault,
   input  wire logic        ref_one_overvoltage,
   input  wire logic        ref_one_undervoltage,
   input  wire logic        primary_clock_timeout,
   input  wire logic [7:0]  pulse_in,
   input  wire logic        hsel,
   input  wire logic [11:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic [7:0]       phase_pulse_output,
   output logic [7:0]       phase_pulse_oe,
   output logic             control_enable,
   output logic             tristate_safe_state,
   output logic             irq
);
   // Fault inputs come from other domains: two flops each
   logic [7:0] lf_m_q;
   logic [7:0] lf_m_d;
   logic [7:0] lf_s_q;
   logic [7:0] lf_s_d;
   logic [7:0] cf_m_q;
   logic [7:0] cf_m_d;
   logic [7:0] cf_s_q;
   logic [7:0] cf_s_d;
   logic [2:0] pf_m_q;
   logic [2:0] pf_m_d;
   logic [2:0] pf_s_q;
   logic [2:0] pf_s_d;

   // Only the second flop of each pair feeds logic
   always_comb
   begin
      lf_m_d = latched_fault;
      lf_s_d = lf_m_q;
      cf_m_d = config_fault;
      cf_s_d = cf_m_q;
      pf_m_d = {primary_clock_timeout, ref_one_undervoltage,
                ref_one_overvoltage};
      pf_s_d = pf_m_q;
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lf_m_q <= 8'h00;
         lf_s_q <= 8'h00;
         cf_m_q <= 8'h00;
         cf_s_q <= 8'h00;
         pf_m_q <= 3'h0;
         pf_s_q <= 3'h0;
      end
      else
      begin
         lf_m_q <= lf_m_d;
         lf_s_q <= lf_s_d;
         cf_m_q <= cf_m_d;
         cf_s_q <= cf_s_d;
         pf_m_q <= pf_m_d;
         pf_s_q <= pf_s_d;
      end
   end

   // Protected path
   logic echo_q;

   sstc_prot_path u_prot
   (
      .clock  (clock),
      .rst_n  (rst_n),
      .ov_s   (pf_s_q[0]),
      .uv_s   (pf_s_q[1]),
      .tmo_s  (pf_s_q[2]),
      .trip_q (echo_q)
   );

   // Registers
   logic [7:0]  frs_q;
   logic [7:0]  frs_d;
   logic [3:0]  mask_q;
   logic [3:0]  mask_d;
   logic [3:0]  stat_q;
   logic [3:0]  stat_d;
   logic [11:0] a_addr_q;
   logic [11:0] a_addr_d;
   logic        a_wr_q;
   logic        a_wr_d;
   logic        rd_take;
   logic [31:0] hrdata_q;
   logic [31:0] hrdata_d;
   logic        irq_q;
   logic        irq_d;
   logic        ready_q;
   logic        ready_d;
   logic        resp_q;
   logic        resp_d;
   sstc_pkg::sstc_state_type st_q;
   sstc_pkg::sstc_state_type st_d;
   logic [7:0]  pout_q;
   logic [7:0]  pout_d;
   logic [7:0]  poe_q;
   logic [7:0]  poe_d;
   logic        en_q;
   logic        en_d;
   logic        safe_q;
   logic        safe_d;
   logic        main_trig;
   logic        cfg_trig;
   logic        lat_trig;
   logic [3:0]  ev;
   logic [3:0]  w1c;
   logic        take;

   // Main path state machine for every trigger the isolated path skips
   always_comb
   begin
      lat_trig  = |lf_s_q;
      cfg_trig  = |(cf_s_q & frs_q);
      main_trig = lat_trig | cfg_trig;
      st_d      = st_q;
      case (st_q)
         sstc_pkg::SSTC_RUN:
            if (echo_q)
               st_d = sstc_pkg::SSTC_PROT_SAFE;
            else if (main_trig)
               st_d = sstc_pkg::SSTC_MAIN_SAFE;
         sstc_pkg::SSTC_MAIN_SAFE:
            if (echo_q)
               st_d = sstc_pkg::SSTC_PROT_SAFE;
         default:
            st_d = st_q;
      endcase
      // Echo drives the pins directly so a broken state machine can't mask it
      safe_d = (st_d != sstc_pkg::SSTC_RUN) | echo_q;
      en_d   = ~safe_d;
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_q   <= sstc_pkg::SSTC_RUN;
         safe_q <= 1'b0;
         en_q   <= 1'b0;
      end
      else
      begin
         st_q   <= st_d;
         safe_q <= safe_d;
         en_q   <= en_d;
      end
   end

   // One driver cell per phase pin, all released together
   for (genvar p = 0; p < `SSTC_PHASES; p++)
   begin : g_phase
      always_comb
      begin
         poe_d[p]  = ~safe_d;
         pout_d[p] = safe_d ? 1'b0 : pulse_in[p];
      end

      always_ff @(posedge clock or negedge rst_n)
      begin
         if (!rst_n)
         begin
            poe_q[p]  <= 1'b0;
            pout_q[p] <= 1'b0;
         end
         else
         begin
            poe_q[p]  <= poe_d[p];
            pout_q[p] <= pout_d[p];
         end
      end
   end

   // Bus slave, zero wait states
   always_comb
   begin
      take     = hsel & hready & (htrans == `SSTC_HTRANS_NONSEQ);
      a_wr_d   = take & hwrite;
      rd_take  = take & ~hwrite;
      a_addr_d = take ? haddr : a_addr_q;
      // Never stalls, never errors, yet held in flops like every output
      ready_d  = 1'b1;
      resp_d   = 1'b0;
      // Fetched in the address phase, shown through the data phase
      hrdata_d = hrdata_q;
      if (rd_take)
      begin
         hrdata_d = 32'h0000_0000;
         if (haddr == `SSTC_OFF_STATUS)
         begin
            hrdata_d[`SSTC_BIT_SAFE] = safe_q;
            hrdata_d[`SSTC_BIT_ECHO] = echo_q;
            hrdata_d[`SSTC_BIT_MAIN] = (st_q == sstc_pkg::SSTC_MAIN_SAFE);
         end
         else if (haddr == `SSTC_OFF_IRQ_STAT)
            hrdata_d[3:0] = stat_q;
         else if (haddr == `SSTC_OFF_IRQ_MASK)
            hrdata_d[3:0] = mask_q;
         else if (haddr == `SSTC_OFF_FRS)
            hrdata_d[7:0] = frs_q;
         else if (haddr == `SSTC_OFF_PHASE_EN)
            hrdata_d[7:0] = poe_q;
         else if (haddr == `SSTC_OFF_PHASE_DAT)
            hrdata_d[7:0] = pout_q;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         a_addr_q <= 12'h000;
         a_wr_q   <= 1'b0;
         hrdata_q <= 32'h0000_0000;
         ready_q  <= 1'b1;
         resp_q   <= 1'b0;
      end
      else
      begin
         a_addr_q <= a_addr_d;
         a_wr_q   <= a_wr_d;
         hrdata_q <= hrdata_d;
         ready_q  <= ready_d;
         resp_q   <= resp_d;
      end
   end

   // Writes land at the end of the data phase; a read issued right
   // behind a write to the same register still sees the old value
   always_comb
   begin
      frs_d  = frs_q;
      mask_d = mask_q;
      w1c    = 4'h0;
      if (a_wr_q)
      begin
         if (a_addr_q == `SSTC_OFF_IRQ_STAT)
            w1c = hwdata[3:0];
         else if (a_addr_q == `SSTC_OFF_IRQ_MASK)
            mask_d = hwdata[3:0];
         else if (a_addr_q == `SSTC_OFF_FRS)
            frs_d = hwdata[7:0];
      end
      ev[`SSTC_BIT_EV_SAFE]   = safe_d & ~safe_q;
      ev[`SSTC_BIT_EV_ECHO]   = echo_q & (st_q != sstc_pkg::SSTC_PROT_SAFE);
      ev[`SSTC_BIT_EV_LATCH]  = lat_trig & (st_q == sstc_pkg::SSTC_RUN);
      ev[`SSTC_BIT_EV_CONFIG] = cfg_trig & (st_q == sstc_pkg::SSTC_RUN);
      // Set wins over a same-cycle clear
      stat_d = (stat_q & ~w1c) | ev;
      irq_d  = |(stat_d & mask_d);
   end

   // No write reaches the safe state; only reset leaves it
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         frs_q  <= `SSTC_RST_FRS;
         mask_q <= `SSTC_RST_MASK;
         stat_q <= 4'h0;
         irq_q  <= 1'b0;
      end
      else
      begin
         frs_q  <= frs_d;
         mask_q <= mask_d;
         stat_q <= stat_d;
         irq_q  <= irq_d;
      end
   end

   // Every output leaves a flop
   assign hrdata              = hrdata_q;
   assign hreadyout           = ready_q;
   assign hresp               = resp_q;
   assign phase_pulse_output  = pout_q;
   assign phase_pulse_oe      = poe_q;
   assign control_enable      = en_q;
   assign tristate_safe_state = safe_q;
   assign irq                 = irq_q;
endmodule

// *** sstc_props.sv ***
// Checker on the safe state block ports
`timescale 1ns/1ps
module sstc_props
(
   input wire logic       clock,
   input wire logic       rst_n,
   input wire logic [7:0] latched_fault,
   input wire logic       ref_one_overvoltage,
   input wire logic       ref_one_undervoltage,
   input wire logic       primary_clock_timeout,
   input wire logic       hreadyout,
   input wire logic       hresp,
   input wire logic [7:0] phase_pulse_output,
   input wire logic [7:0] phase_pulse_oe,
   input wire logic       control_enable,
   input wire logic       tristate_safe_state
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   wire prot = ref_one_overvoltage | ref_one_undervoltage
      | primary_clock_timeout;
   a_safe_floats: assert property (
      tristate_safe_state |-> phase_pulse_oe == 8'h00 && !control_enable)
      else $error("pins driven in safe state");
   a_safe_quiet: assert property (
      tristate_safe_state |-> phase_pulse_output == 8'h00)
      else $error("pulse data in safe state");
   a_runs_when_ok: assert property (
      !tristate_safe_state && $past(rst_n) |-> control_enable
      && phase_pulse_oe == 8'hff) else $error("idle outside safe state");
   a_latch_enters: assert property (
      latched_fault != 8'h00 |-> ##[1:3] tristate_safe_state)
      else $error("latched fault missed");
   a_prot_enters: assert property (
      prot |-> ##[1:4] tristate_safe_state)
      else $error("protected trip missed");
   a_safe_sticky: assert property (
      tristate_safe_state |=> tristate_safe_state)
      else $error("safe state left");
   a_bus_ready: assert property (hreadyout)
      else $error("wait state seen");
   a_bus_okay: assert property (!hresp)
      else $error("error response seen");
endmodule
bind sstc_safe_state_top sstc_props u_sstc_props
(
   .clock, .rst_n, .latched_fault, .ref_one_overvoltage,
   .ref_one_undervoltage, .primary_clock_timeout, .hreadyout, .hresp,
   .phase_pulse_output, .phase_pulse_oe, .control_enable,
   .tristate_safe_state
);

// *** sstc_stage_model.sv ***
// Power stage inputs resolving the phase pins
`timescale 1ns/1ps
module sstc_stage_model
(
   input  wire logic [7:0] drive,
   input  wire logic [7:0] oe,
   output logic      [7:0] floating
);
   wire [7:0] pin;
   for (genvar i = 0; i < 8; i++)
   begin : g_pin
      assign pin[i] = oe[i] ? drive[i] : 1'bz;
      assign floating[i] = (pin[i] === 1'bz);
   end
endmodule

// *** sstc_safe_state_top_tb.sv ***
// Self-checking bench for the safe state block
`timescale 1ns/1ps
`include "sstc_cfg.svh"
module sstc_safe_state_top_tb;
   logic        clock = 1'b0;
   logic        rst_n = 1'b0;
   logic [18:0] fi = 19'h0_0000;
   logic [7:0]  pi = 8'h00;
   logic        hsel = 1'b0;
   logic [11:0] haddr = 12'h000;
   logic [1:0]  htrans = 2'b00;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'b010;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata, q;
   logic        hreadyout, hresp, ce, safe, irq;
   logic [7:0]  po, oe, flt;
   int          n_fail = 0;
   int          samples_checked = 0;
   wire [31:0]  obs = {6'h00, safe, ce, po, oe, flt};
   always #2.5 clock = ~clock;
   sstc_safe_state_top u_sstc_safe_state_top
   (
      .clock(clock), .rst_n(rst_n), .latched_fault(fi[7:0]),
      .config_fault(fi[15:8]), .ref_one_overvoltage(fi[16]),
      .ref_one_undervoltage(fi[17]), .primary_clock_timeout(fi[18]),
      .pulse_in(pi), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .phase_pulse_output(po), .phase_pulse_oe(oe),
      .control_enable(ce), .tristate_safe_state(safe), .irq(irq)
   );
   sstc_stage_model u_sstc_stage_model
   (
      .drive(po), .oe(oe), .floating(flt)
   );
   function automatic logic [31:0] pins(input logic s);
      return s ? 32'h0200_00ff : {8'h01, pi, 16'hff00};
   endfunction
   function automatic logic [31:0] status_exp(input logic prot);
      return prot ? 32'h0000_0003 : 32'h0000_0005;
   endfunction
   task automatic bus(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      @(posedge clock);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= `SSTC_HTRANS_NONSEQ;
      do @(posedge clock); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clock); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e)
      begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000);
      cmp(q, e);
   endtask
   task automatic rst();
      @(posedge clock);
      rst_n <= 1'b0;
      fi <= 19'h0_0000;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      pi <= $urandom;
      repeat (3) @(posedge clock);
   endtask
   task automatic finish_test();
      $display("checked %0d failed %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      #100000;
      n_fail++;
      finish_test();
   end
   initial
   begin
      int n;
      void'($urandom(59));
      rst();
      cmp(obs, pins(1'b0));
      rdc(`SSTC_OFF_FRS, 32'h0000_0000);
      rdc(`SSTC_OFF_IRQ_MASK, 32'h0000_0000);
      rdc(`SSTC_OFF_STATUS, 32'h0000_0000);
      rdc(12'h020, 32'h0000_0000);
      n = $urandom % 8;
      fi[15:8] <= 8'h01 << n;
      repeat (6) @(posedge clock);
      cmp(obs, pins(1'b0));
      bus(1'b1, `SSTC_OFF_FRS, 32'h0000_0001 << n);
      repeat (6) @(posedge clock);
      cmp(obs, pins(1'b1));
      rdc(`SSTC_OFF_STATUS, 32'h0000_0005);
      rdc(`SSTC_OFF_IRQ_STAT, 32'h0000_0009);
      fi <= 19'h0_0000;
      bus(1'b1, `SSTC_OFF_IRQ_MASK, 32'h0000_0008);
      repeat (2) @(posedge clock);
      cmp(irq, 1'b1);
      bus(1'b1, `SSTC_OFF_IRQ_MASK, 32'h0000_0000);
      repeat (2) @(posedge clock);
      cmp(irq, 1'b0);
      bus(1'b1, `SSTC_OFF_IRQ_MASK, 32'h0000_000f);
      bus(1'b1, `SSTC_OFF_IRQ_STAT, 32'h0000_000f);
      repeat (2) @(posedge clock);
      cmp(irq, 1'b0);
      cmp(obs, pins(1'b1));
      $display("test config done");
      for (int k = 0; k < 4; k++)
      begin
         rst();
         cmp(obs, pins(1'b0));
         rdc(`SSTC_OFF_PHASE_EN, 32'h0000_00ff);
         rdc(`SSTC_OFF_PHASE_DAT, {24'h00_0000, pi});
         n = $urandom % 8;
         fi <= (k < 3) ? (19'h0_0001 << (16 + k)) : (19'h0_0001 << n);
         repeat (8) @(posedge clock);
         cmp(obs, pins(1'b1));
         rdc(`SSTC_OFF_STATUS, status_exp(k < 3));
         rdc(`SSTC_OFF_PHASE_EN, 32'h0000_0000);
         rdc(`SSTC_OFF_PHASE_DAT, 32'h0000_0000);
         fi <= 19'h0_0000;
         repeat (4) @(posedge clock);
         cmp(obs, pins(1'b1));
         rdc(`SSTC_OFF_STATUS, status_exp(k < 3));
         $display("test trip %0d done", k);
      end
      finish_test();
   end
endmodule
